// >>> include/mmm_defs.svh
/*
 Address map, reset values and operand widths of the memory mapped multiplier.
 Assumes a 16-bit word address bus driven by the CPU core.
*/
`ifndef MMM_DEFS_SVH
`define MMM_DEFS_SVH

`define MMM_ADDR_UNSIGNED_A 16'h0130
`define MMM_ADDR_SIGNED_A 16'h0132
`define MMM_ADDR_ACCUM_A 16'h0134
`define MMM_ADDR_SACCUM_A 16'h0136
`define MMM_ADDR_SECOND 16'h0138
`define MMM_ADDR_PROD_LO 16'h013a
`define MMM_ADDR_PROD_HI 16'h013c
`define MMM_ADDR_CARRY_SIGN 16'h013e

`define MMM_RESET_WORD 16'h0000
`define MMM_BYTE_MSB 7
`define MMM_WORD_MSB 15

`endif

// >>> include/mmm_pkg.sv
/*
 Types of the memory mapped multiplier: operation mode and register state.
 Assumes mmm_defs.svh for addresses and reset values.
*/
package mmm_pkg;

   typedef enum logic [3:0] {
      MMM_UMUL = 4'b0001,
      MMM_SMUL = 4'b0010,
      MMM_UACC = 4'b0100,
      MMM_SACC = 4'b1000
   } mmm_mode_t;

   typedef struct packed {
      logic [15:0] op_a;
      logic [15:0] op_b;
      mmm_mode_t mode;
      logic [15:0] prod_lo;
      logic [15:0] prod_hi;
      logic [15:0] carry_sign;
      logic [15:0] rdata;
   } mmm_state_t;

endpackage

// >>> verilog/mmm_arith.sv
/*
 Combinational multiply and accumulate datapath.
 Assumes operands already extended to 16 bits by the register block.
*/
`timescale 1ns/1ns
module mmm_arith (
   input wire logic [15:0] op_a,
   input wire logic [15:0] op_b,
   input wire logic is_signed,
   input wire logic is_accum,
   input wire logic [31:0] acc_in,
   output logic [31:0] sum,
   output logic [15:0] ext
);
   logic [31:0] prod_u;
   logic signed [31:0] prod_s;
   logic [31:0] prod;
   logic [32:0] total;

   always_comb begin
      prod_u = op_a * op_b;
      prod_s = $signed(op_a) * $signed(op_b);
      prod = is_signed ? prod_s : prod_u;
      // Accumulate adds to the result already held
      total = is_accum ? ({1'b0, acc_in} + {1'b0, prod}) : {1'b0, prod};
      sum = total[31:0];
      if (is_signed) begin
         ext = {16{total[31]}};
      end else if (is_accum) begin
         ext = {15'h0000, total[32]};
      end else begin
         ext = 16'h0000;
      end
   end
endmodule // mmm_arith

// >>> verilog/mmm_top.sv
/*
 Memory mapped multiplier: operand and result registers on the peripheral bus.
 Assumes a CPU bus master on CLK giving one-cycle WE or RE strobes with ADDR.
*/
`timescale 1ns/1ns
`include "mmm_defs.svh"

// Summary of operation
// - Operands may be 16 or 8 bits in any pairing, separate unit.
// - Signed and unsigned multiply give the full 32-bit product.
// - Accumulate modes add each new product to the held result.
// - First operand address picks unsigned, signed, accumulate or signed accumulate.
// - Writing the second operand makes the result ready for the next read.
// - No wait states; the result lands on the operand write edge.
// - Low word, high word and extension word are readable at fixed words.
module mmm_top (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [15:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WE,
   input wire logic BYTE,
   input wire logic RE,
   output logic [15:0] RDATA
);
   mmm_pkg::mmm_state_t s_reg;
   mmm_pkg::mmm_state_t s_next;
   logic wr_ua;
   logic wr_sa;
   logic wr_aa;
   logic wr_saa;
   logic wr_first;
   logic wr_second;
   logic sel_signed;
   logic sel_accum;
   logic [15:0] first_val;
   logic [15:0] second_val;
   logic [31:0] arith_sum;
   logic [15:0] arith_ext;

   assign wr_ua = WE && (ADDR == `MMM_ADDR_UNSIGNED_A);
   assign wr_sa = WE && (ADDR == `MMM_ADDR_SIGNED_A);
   assign wr_aa = WE && (ADDR == `MMM_ADDR_ACCUM_A);
   assign wr_saa = WE && (ADDR == `MMM_ADDR_SACCUM_A);
   assign wr_first = wr_ua || wr_sa || wr_aa || wr_saa;
   assign wr_second = WE && (ADDR == `MMM_ADDR_SECOND);
   assign sel_signed = (s_reg.mode == mmm_pkg::MMM_SMUL) || (s_reg.mode == mmm_pkg::MMM_SACC);
   assign sel_accum = (s_reg.mode == mmm_pkg::MMM_UACC) || (s_reg.mode == mmm_pkg::MMM_SACC);

   // Byte writes extend to 16 bits by the signedness of the mode
   always_comb begin
      if (!BYTE) begin
         first_val = WDATA;
         second_val = WDATA;
      end else begin
         first_val = {{8{(wr_sa || wr_saa) && WDATA[`MMM_BYTE_MSB]}}, WDATA[7:0]};
         second_val = {{8{sel_signed && WDATA[`MMM_BYTE_MSB]}}, WDATA[7:0]};
      end
   end

   mmm_arith u_arith (
      .op_a(s_reg.op_a),
      .op_b(second_val),
      .is_signed(sel_signed),
      .is_accum(sel_accum),
      .acc_in({s_reg.prod_hi, s_reg.prod_lo}),
      .sum(arith_sum),
      .ext(arith_ext)
   );

   always_comb begin
      s_next = s_reg;
      if (wr_first) begin
         s_next.op_a = first_val;
         unique case (1'b1)
            wr_ua: s_next.mode = mmm_pkg::MMM_UMUL;
            wr_sa: s_next.mode = mmm_pkg::MMM_SMUL;
            wr_aa: s_next.mode = mmm_pkg::MMM_UACC;
            wr_saa: s_next.mode = mmm_pkg::MMM_SACC;
         endcase
      end
      if (wr_second) begin
         // Result settles on this same edge, no wait state
         s_next.op_b = second_val;
         s_next.prod_lo = arith_sum[15:0];
         s_next.prod_hi = arith_sum[31:16];
         s_next.carry_sign = arith_ext;
      end
      if (WE && ADDR == `MMM_ADDR_PROD_LO) begin
         s_next.prod_lo = BYTE ? {8'h00, WDATA[7:0]} : WDATA;
      end
      if (WE && ADDR == `MMM_ADDR_PROD_HI) begin
         s_next.prod_hi = BYTE ? {8'h00, WDATA[7:0]} : WDATA;
      end
      if (RE) begin
         unique case (ADDR)
            `MMM_ADDR_UNSIGNED_A,
            `MMM_ADDR_SIGNED_A,
            `MMM_ADDR_ACCUM_A,
            `MMM_ADDR_SACCUM_A: s_next.rdata = s_reg.op_a;
            `MMM_ADDR_SECOND: s_next.rdata = s_reg.op_b;
            `MMM_ADDR_PROD_LO: s_next.rdata = s_reg.prod_lo;
            `MMM_ADDR_PROD_HI: s_next.rdata = s_reg.prod_hi;
            `MMM_ADDR_CARRY_SIGN: s_next.rdata = s_reg.carry_sign;
            default: s_next.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         s_reg.op_a <= `MMM_RESET_WORD;
         s_reg.op_b <= `MMM_RESET_WORD;
         s_reg.mode <= mmm_pkg::MMM_UMUL;
         s_reg.prod_lo <= `MMM_RESET_WORD;
         s_reg.prod_hi <= `MMM_RESET_WORD;
         s_reg.carry_sign <= `MMM_RESET_WORD;
         s_reg.rdata <= `MMM_RESET_WORD;
      end else begin
         s_reg <= s_next;
      end
   end

   assign RDATA = s_reg.rdata;

   // Checks
   sequence second_write_s;
      WE && ADDR == `MMM_ADDR_SECOND;
   endsequence

   sequence read_lo_s;
      RE && !WE && ADDR == `MMM_ADDR_PROD_LO;
   endsequence

   mode_select_a: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_aa |=> s_reg.mode == mmm_pkg::MMM_UACC)
      else $error("accumulate address did not select accumulate mode");

   mode_signed_a: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_saa ##1 !wr_first[*2] |=> s_reg.mode == mmm_pkg::MMM_SACC)
      else $error("signed accumulate mode not held");

   umul_result_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (second_write_s and s_reg.mode == mmm_pkg::MMM_UMUL) |=>
      {s_reg.prod_hi, s_reg.prod_lo} == $past(s_reg.op_a) * $past(second_val))
      else $error("unsigned product wrong");

   smul_ext_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (second_write_s and s_reg.mode == mmm_pkg::MMM_SMUL) |=>
      s_reg.carry_sign == {16{s_reg.prod_hi[15]}})
      else $error("signed extension word wrong");

   uacc_sum_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (second_write_s and s_reg.mode == mmm_pkg::MMM_UACC) |=>
      {s_reg.carry_sign[0], s_reg.prod_hi, s_reg.prod_lo} ==
      {1'b0, $past(s_reg.prod_hi), $past(s_reg.prod_lo)} +
      33'($past(s_reg.op_a) * $past(second_val)))
      else $error("unsigned accumulate wrong");

   read_next_a: assert property (@(posedge CLK) disable iff (!RESETN)
      second_write_s ##1 read_lo_s |=> RDATA == $past(arith_sum[15:0], 2))
      else $error("result not seen by the next read");

   ext_readonly_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (WE && ADDR == `MMM_ADDR_CARRY_SIGN) |=> $stable(s_reg.carry_sign))
      else $error("extension word changed by a bus write");

   byte_operand_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (wr_ua && BYTE) |=> s_reg.op_a == {8'h00, $past(WDATA[7:0])})
      else $error("byte operand not zero extended");

   unmapped_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (RE && (ADDR < `MMM_ADDR_UNSIGNED_A)) |=> RDATA == 16'h0000)
      else $error("unmapped read not zero");

   smul_result_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (second_write_s and s_reg.mode == mmm_pkg::MMM_SMUL) |=>
      {s_reg.prod_hi, s_reg.prod_lo} ==
      {{16{$past(s_reg.op_a[15])}}, $past(s_reg.op_a)} *
      {{16{$past(second_val[15])}}, $past(second_val)})
      else $error("signed product wrong");

   sacc_sum_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (second_write_s and s_reg.mode == mmm_pkg::MMM_SACC) |=>
      {s_reg.prod_hi, s_reg.prod_lo} ==
      {$past(s_reg.prod_hi), $past(s_reg.prod_lo)} +
      {{16{$past(s_reg.op_a[15])}}, $past(s_reg.op_a)} *
      {{16{$past(second_val[15])}}, $past(second_val)})
      else $error("signed accumulate wrong");

   umul_ext_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (second_write_s and s_reg.mode == mmm_pkg::MMM_UMUL) |=> s_reg.carry_sign == 16'h0000)
      else $error("unsigned extension word not zero");

   sacc_ext_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (second_write_s and s_reg.mode == mmm_pkg::MMM_SACC) |=>
      s_reg.carry_sign == {16{s_reg.prod_hi[15]}})
      else $error("signed accumulate extension wrong");

   byte_signed_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (wr_sa && BYTE) |=> s_reg.op_a == {{8{$past(WDATA[7])}}, $past(WDATA[7:0])})
      else $error("signed byte operand not sign extended");

   byte_second_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (wr_second && BYTE && sel_signed) |=>
      s_reg.op_b == {{8{$past(WDATA[7])}}, $past(WDATA[7:0])})
      else $error("signed byte second operand not sign extended");

   word_operand_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (wr_first && !BYTE) |=> s_reg.op_a == $past(WDATA))
      else $error("word first operand not stored");

   read_operand_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (RE && ADDR == `MMM_ADDR_SACCUM_A) |=> RDATA == $past(s_reg.op_a))
      else $error("first operand read back wrong");

   preload_lo_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (WE && !BYTE && ADDR == `MMM_ADDR_PROD_LO) |=> s_reg.prod_lo == $past(WDATA))
      else $error("low word preload not stored");

   preload_hi_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (WE && !BYTE && ADDR == `MMM_ADDR_PROD_HI) |=> s_reg.prod_hi == $past(WDATA))
      else $error("high word preload not stored");

   rdata_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
      !RE |=> $stable(RDATA))
      else $error("read data changed without a read");

endmodule // mmm_top

// >>> verification/mmm_cpu_model.sv
/*
 CPU bus master model driving the multiplier registers.
 Assumes tasks are called at a falling edge of clk.
*/
`timescale 1ns/1ns
module mmm_cpu_model (
   input wire logic clk,
   input wire logic [15:0] rdata,
   output logic [15:0] addr,
   output logic [15:0] wdata,
   output logic we,
   output logic byte_sel,
   output logic re
);
   initial begin
      addr = 16'h0000;
      wdata = 16'h0000;
      we = 1'b0;
      byte_sel = 1'b0;
      re = 1'b0;
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b);
      addr = a;
      wdata = d;
      byte_sel = b;
      we = 1'b1;
      re = 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      addr = a;
      wdata = ~wdata;
      re = 1'b1;
      we = 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic idle();
      addr = ~addr;
      we = 1'b0;
      re = 1'b0;
      @(negedge clk);
   endtask
endmodule // mmm_cpu_model

// >>> verification/tb.sv
/*
 Self-checking bench of the multiplier.
 Assumes mmm_cpu_model as bus master.
*/
`timescale 1ns/1ns
`include "mmm_defs.svh"
module tb;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   logic [15:0] ADDR, WDATA, RDATA;
   logic WE, BYTE, RE;
   int fails = 0;
   int check_count = 0;
   mmm_top DUT (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WE(WE),
      .BYTE(BYTE), .RE(RE), .RDATA(RDATA));
   mmm_cpu_model cpu (.clk(CLK), .rdata(RDATA), .addr(ADDR), .wdata(WDATA), .we(WE),
      .byte_sel(BYTE), .re(RE));
   always #2 CLK = ~CLK;
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [15:0] ext8(input logic [15:0] v, input logic b, input logic s);
      return !b ? v : (s ? {{8{v[7]}}, v[7:0]} : {8'h00, v[7:0]});
   endfunction
   function automatic logic [47:0] calc(input logic [1:0] m, input logic [15:0] a,
      input logic [15:0] b, input logic [31:0] r);
      logic [31:0] p;
      logic [32:0] s;
      p = (m[0] ? {{16{a[15]}}, a} : {16'h0000, a}) *
         (m[0] ? {{16{b[15]}}, b} : {16'h0000, b});
      s = {1'b0, p} + (m[1] ? {1'b0, r} : 33'h0);
      return {m[0] ? {16{s[31]}} : {15'h0, s[32]}, s[31:0]};
   endfunction
   initial begin
      logic [15:0] a, b, d;
      logic [1:0] m;
      logic ba, bb;
      logic [31:0] r;
      logic [47:0] e;
      r = 32'h0;
      void'($urandom(19));
      repeat (20) @(posedge CLK);
      @(negedge CLK);
      RESETN = 1'b1;
      cpu.rd(`MMM_ADDR_PROD_LO, d);
      chk("reset low", d, 16'h0000);
      cpu.rd(16'h0140, d);
      chk("unmapped", d, 16'h0000);
      for (int i = 0; i < 200; i++) begin
         m = 2'($urandom);
         a = 16'($urandom);
         b = 16'($urandom);
         ba = 1'($urandom);
         bb = 1'($urandom);
         // Full-scale operands in every mode first
         if (i < 4) begin
            m = 2'(i);
            a = 16'hffff;
            b = 16'hffff;
            ba = 1'b0;
            bb = 1'b0;
         end
         // Reset in mid-run clears the result registers
         if (i == 100) begin
            RESETN = 1'b0;
            repeat (2) @(negedge CLK);
            RESETN = 1'b1;
            r = 32'h0;
            cpu.rd(`MMM_ADDR_PROD_HI, d);
            chk("reset high", d, 16'h0000);
            cpu.rd(`MMM_ADDR_CARRY_SIGN, d);
            chk("reset extension", d, 16'h0000);
            cpu.rd(`MMM_ADDR_SECOND, d);
            chk("reset second", d, 16'h0000);
         end
         // Preload, word or zero extended byte
         if (i % 16 == 5) begin
            r = $urandom;
            cpu.wr(`MMM_ADDR_PROD_LO, r[15:0], i[4]);
            cpu.wr(`MMM_ADDR_PROD_HI, r[31:16], i[4]);
            r = {ext8(r[31:16], i[4], 1'b0), ext8(r[15:0], i[4], 1'b0)};
         end
         cpu.wr(`MMM_ADDR_UNSIGNED_A + {13'h0, m, 1'b0}, a, ba);
         cpu.wr(`MMM_ADDR_SECOND, b, bb);
         e = calc(m, ext8(a, ba, m[0]), ext8(b, bb, m[0]), r);
         r = e[31:0];
         cpu.rd(`MMM_ADDR_PROD_LO, d);
         chk("low word", d, e[15:0]);
         cpu.rd(`MMM_ADDR_PROD_HI, d);
         chk("high word", d, e[31:16]);
         cpu.wr(`MMM_ADDR_CARRY_SIGN, ~e[47:32], 1'b0);
         cpu.rd(`MMM_ADDR_CARRY_SIGN, d);
         chk("extension word", d, e[47:32]);
         cpu.rd(`MMM_ADDR_UNSIGNED_A + {13'h0, m, 1'b0}, d);
         chk("first operand", d, ext8(a, ba, m[0]));
         cpu.rd(`MMM_ADDR_SECOND, d);
         chk("second operand", d, ext8(b, bb, m[0]));
         if (i % 8 == 0) cpu.idle();
      end
      results();
   end
   // Cut a hang short
   initial begin
      #40000;
      fails++;
      results();
   end
endmodule // tb
